//--- hw/cmd_dma_defs.svh
`ifndef CMD_DMA_DEFS_SVH
`define CMD_DMA_DEFS_SVH

`define CMD_DATA_ADDR    16'h1400
`define CMD_STATUS_ADDR  16'h1800
`define CMD_PENDING_BIT  0
`define DMA_WINDOW_BIT   15
`define BUF_DEPTH        2
`define CMD_RESET        8'h00

`endif

//--- hw/cmd_dma_pkg.sv
package cmd_dma_pkg;

  typedef enum logic [2:0] {
    SEQ_CLEAR = 3'b000,
    SEQ_LOAD  = 3'b001,
    SEQ_ACKW  = 3'b010,
    SEQ_ACT   = 3'b011,
    SEQ_WAIT  = 3'b100,
    SEQ_XFER  = 3'b101,
    SEQ_PARK  = 3'b110
  } seq_state_t;

endpackage : cmd_dma_pkg

//--- hw/command_port_dma_channel.sv
// Operation
// - Latch host byte when port address matches with write strobe and output status.
// - Latching sets the pending flag, asserting pending output and a hold request.
// - Local read of 1800H returns the pending flag on bit 0.
// - Local read of 1400H returns the latched command byte.
// - Reading 1400H clears the pending flag and withdraws its hold request.
// - Local accesses in upper 32K become host accesses in lower 32K.
// - Page input redirects accesses to the upper 32K of host memory.
// - Address bit 15 with a strobe low stalls the local processor and requests hold.
// - Idle with priority high and hold line free: pull hold low on phase-2 fall.
// - Host acknowledges hold; device then drives host address and control buses.
// - First stage set: DMA active, data buffers on, direction from read strobe.
// - Next phase-2 fall: wait status high, write strobe low for writes.
// - One period later: host ready is passed to local ready on writes; reads resume on buffered data.
// - Transaction ends with both strobes high; no command pending releases hold.
// - Command pending at end keeps host held and host buses driven, with DMA inactive and wait status low.
// - While held for a command, further transfers skip the acknowledge wait.
// - Priority out low when priority in low or transferring.
// - Defer requests until priority in and hold line are high.
// - Hold and priority out go low together on a phase-2 fall.
// - Priority in low at the next phase-2 fall aborts the request.
// - Priority resolves every request still unacknowledged at a phase-2 fall, whenever it started.
// - Host command port address is any 8-bit value.
`timescale 1ns/100ps
`include "cmd_dma_defs.svh"

module command_port_dma_channel (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        host_phi2,
  input  wire logic [7:0]  port_addr,
  input  wire logic [7:0]  host_addr,
  input  wire logic [7:0]  host_data_in,
  input  wire logic        host_write_strobe,
  input  wire logic        host_output_status,
  input  wire logic        host_hold_req_n_in,
  input  wire logic        host_hold_ack,
  input  wire logic        host_ready,
  input  wire logic        priority_in_n,
  input  wire logic [15:0] local_addr,
  input  wire logic        local_mem_read_n,
  input  wire logic        local_mem_write_n,
  input  wire logic [7:0]  local_data_in,
  input  wire logic        page_upper,
  input  wire logic        local_rd_ready,
  output logic             host_hold_req_n_out,
  output logic             host_hold_req_n_oe,
  output logic             host_bus_oe,
  output logic [15:0]      host_addr_out,
  output logic             host_wait_status,
  output logic             host_mem_write_n,
  output logic [7:0]       host_data_out,
  output logic             host_data_oe,
  output logic             priority_out_n,
  output logic             command_pending_n,
  output logic             dma_active,
  output logic             local_ready_in,
  output logic [7:0]       local_data_out,
  output logic             local_data_oe,
  output logic             local_rd_valid
);
  import cmd_dma_pkg::*;

  localparam int ASYNC_W = 31;
  // Reset to the pins' idle levels so no false edge, hold or priority shows after reset
  localparam logic [ASYNC_W-1:0] SYNC_IDLE = {1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1,
                                               24'h000000};

  logic [ASYNC_W-1:0] sync1;
  logic [ASYNC_W-1:0] sync2;
  logic               phi2_prev;
  logic               load_prev;
  logic               data_rd_prev;
  logic               command_pending;
  logic [7:0]         cmd_byte;
  seq_state_t         state;
  logic               captured;
  logic [7:0]         buf_mem [`BUF_DEPTH];
  logic               buf_wr_ptr;
  logic               buf_rd_ptr;
  logic [1:0]         buf_count;

  logic       phi2_s;
  logic       wr_strobe_s;
  logic       out_status_s;
  logic       hold_line_s;
  logic       hold_ack_s;
  logic       ready_s;
  logic       prio_in_n_s;
  logic [7:0] haddr_s;
  logic [7:0] hdata_s;
  logic [7:0] port_addr_s;

  assign {phi2_s, wr_strobe_s, out_status_s, hold_line_s, hold_ack_s, ready_s,
          prio_in_n_s, haddr_s, hdata_s, port_addr_s} = sync2;

  function automatic logic addr_hit(input logic [15:0] a, input logic [15:0] b);
    return a == b;
  endfunction : addr_hit

  logic phi2_fall;
  logic port_addr_match;
  logic command_load;
  logic cmd_data_sel;
  logic cmd_status_sel;
  logic dma_req;
  logic strobes_idle;
  logic local_read;
  logic in_xfer;
  logic buf_in_ready;
  logic buf_push;
  logic buf_pop;

  assign phi2_fall       = phi2_prev & ~phi2_s;
  assign port_addr_match = haddr_s == port_addr_s;
  assign command_load    = port_addr_match & wr_strobe_s & out_status_s;
  assign local_read      = ~local_mem_read_n;
  assign cmd_data_sel    = local_read & addr_hit(local_addr, `CMD_DATA_ADDR);
  assign cmd_status_sel  = local_read & addr_hit(local_addr, `CMD_STATUS_ADDR);
  assign dma_req         = local_addr[`DMA_WINDOW_BIT] &
                           (~local_mem_read_n | ~local_mem_write_n);
  assign strobes_idle    = local_mem_read_n & local_mem_write_n;
  assign in_xfer         = state == SEQ_ACT || state == SEQ_WAIT || state == SEQ_XFER;

  // Every host pin is foreign to ref_clk; the whole group shares one synchroniser
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1 <= SYNC_IDLE;
      sync2 <= SYNC_IDLE;
    end
    else if (clk_en)
    begin
      sync1 <= {host_phi2, host_write_strobe, host_output_status, host_hold_req_n_in,
                host_hold_ack, host_ready, priority_in_n, host_addr, host_data_in,
                port_addr};
      sync2 <= sync1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phi2_prev    <= 1'b0;
      load_prev    <= 1'b0;
      data_rd_prev <= 1'b0;
    end
    else if (clk_en)
    begin
      phi2_prev    <= phi2_s;
      load_prev    <= command_load;
      data_rd_prev <= cmd_data_sel;
    end
  end

  // Command latch and service-request flag; a load in the clearing cycle wins
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_byte        <= `CMD_RESET;
      command_pending <= 1'b0;
    end
    else if (clk_en)
    begin
      if (command_load && !load_prev)
      begin
        cmd_byte        <= hdata_s;
        command_pending <= 1'b1;
      end
      else if (cmd_data_sel && !data_rd_prev)
        command_pending <= 1'b0;
    end
  end

  assign command_pending_n = ~command_pending;

  // Sequencer; hold start, abort, stage steps and parked restarts wait for trailing edges of the host phase-2 clock
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= SEQ_CLEAR;
    else if (clk_en)
    begin
      unique case (state)
        SEQ_CLEAR:
          if ((dma_req || command_pending) && prio_in_n_s)
            state <= SEQ_LOAD;
        SEQ_LOAD:
          if (!(dma_req || command_pending) || !prio_in_n_s)
            state <= SEQ_CLEAR;
          else if (phi2_fall && hold_line_s)
            state <= SEQ_ACKW;
        SEQ_ACKW:
          if (phi2_fall && !prio_in_n_s && !hold_ack_s)
            state <= SEQ_CLEAR;
          else if (hold_ack_s)
          begin
            if (dma_req)
              state <= SEQ_ACT;
            else if (command_pending)
              state <= SEQ_PARK;
            else
              state <= SEQ_CLEAR;
          end
        SEQ_ACT, SEQ_WAIT, SEQ_XFER:
          if (strobes_idle)
            state <= command_pending ? SEQ_PARK : SEQ_CLEAR;
          else if (phi2_fall && state == SEQ_ACT)
            state <= SEQ_WAIT;
          else if (phi2_fall && state == SEQ_WAIT)
            state <= SEQ_XFER;
        SEQ_PARK:
          if (dma_req && phi2_fall)
            state <= SEQ_ACT;
          else if (!command_pending && !dma_req)
            state <= SEQ_CLEAR;
        default:
          state <= SEQ_CLEAR;
      endcase
    end
  end

  // Hold stays asserted from the request until the transfer or parked hold ends, or until SEQ_ACKW abandons the request
  assign host_hold_req_n_oe  = state != SEQ_CLEAR && state != SEQ_LOAD;
  assign host_hold_req_n_out = 1'b0;
  assign priority_out_n      = ~(~prio_in_n_s | host_hold_req_n_oe);
  assign dma_active          = in_xfer;
  assign host_bus_oe         = in_xfer || state == SEQ_PARK;
  assign host_wait_status    = state == SEQ_WAIT || state == SEQ_XFER;
  assign host_mem_write_n    = ~(host_wait_status & ~local_mem_write_n);
  assign host_data_oe        = in_xfer & local_mem_read_n;

  // Host address and data registered; the stalled local side keeps them steady
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      host_addr_out <= 16'h0000;
      host_data_out <= 8'h00;
    end
    else if (clk_en)
    begin
      host_addr_out <= {page_upper, local_addr[14:0]};
      host_data_out <= local_data_in;
    end
  end

  // Read data buffer: a stalled local reader holds off capture from the host bus
  assign buf_in_ready   = buf_count != 2'(`BUF_DEPTH);
  assign local_rd_valid = buf_count != 2'd0;
  assign buf_push       = state == SEQ_XFER && local_read && !captured && ready_s &&
                          buf_in_ready;
  assign buf_pop        = local_rd_valid & local_rd_ready;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      buf_wr_ptr <= 1'b0;
      buf_rd_ptr <= 1'b0;
      buf_count  <= 2'd0;
      captured   <= 1'b0;
    end
    else if (clk_en)
    begin
      if (buf_push)
      begin
        buf_mem[buf_wr_ptr] <= hdata_s;
        buf_wr_ptr          <= ~buf_wr_ptr;
      end
      if (buf_pop)
        buf_rd_ptr <= ~buf_rd_ptr;
      buf_count <= 2'(buf_count + {1'b0, buf_push} - {1'b0, buf_pop});
      if (!in_xfer)
        captured <= 1'b0;
      else if (buf_push)
        captured <= 1'b1;
    end
  end

  // Local ready is a handshake; a write resumes on host ready, a read on buffered data
  assign local_ready_in = ~dma_req | (state == SEQ_XFER &
                          (local_read ? local_rd_valid : ready_s));

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      local_data_out <= 8'h00;
    else if (clk_en)
    begin
      if (cmd_data_sel)
        local_data_out <= cmd_byte;
      else if (cmd_status_sel)
        local_data_out <= {7'h00, command_pending};
      else if (local_rd_valid)
        local_data_out <= buf_mem[buf_rd_ptr];
    end
  end

  assign local_data_oe = cmd_data_sel | cmd_status_sel | (dma_req & local_read);

  property p_load;
    @(posedge ref_clk) disable iff (!rst_n)
      clk_en && command_load && !load_prev |=> command_pending && cmd_byte == $past(hdata_s);
  endproperty
  a_load: assert property (p_load) else $error("command byte not latched");

  property p_clear;
    @(posedge ref_clk) disable iff (!rst_n)
      clk_en && cmd_data_sel && !data_rd_prev && !(command_load && !load_prev)
      |=> !command_pending && command_pending_n;
  endproperty
  a_clear: assert property (p_clear) else $error("pending not cleared");

  property p_status;
    @(posedge ref_clk) disable iff (!rst_n)
      clk_en && cmd_status_sel && !(command_load && !load_prev)
      |=> local_data_out[`CMD_PENDING_BIT] == command_pending;
  endproperty
  a_status: assert property (p_status) else $error("status bit wrong");

  property p_prio;
    @(posedge ref_clk) disable iff (!rst_n)
      !prio_in_n_s || in_xfer |-> !priority_out_n;
  endproperty
  a_prio: assert property (p_prio) else $error("priority out not low");

  property p_hold_start;
    @(posedge ref_clk) disable iff (!rst_n)
      state == SEQ_LOAD ##1 state == SEQ_ACKW
      |-> $past(phi2_fall) && host_hold_req_n_oe && !priority_out_n;
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("hold start wrong");

  property p_abort;
    @(posedge ref_clk) disable iff (!rst_n)
      clk_en && state == SEQ_ACKW && phi2_fall && !prio_in_n_s && !hold_ack_s
      |=> state == SEQ_CLEAR && !host_hold_req_n_oe;
  endproperty
  a_abort: assert property (p_abort) else $error("abort missed");

  property p_write;
    @(posedge ref_clk) disable iff (!rst_n)
      state == SEQ_WAIT && !local_mem_write_n |-> !host_mem_write_n && host_wait_status;
  endproperty
  a_write: assert property (p_write) else $error("host write strobe missing");

  property p_end;
    @(posedge ref_clk) disable iff (!rst_n)
      clk_en && in_xfer && strobes_idle
      |=> ($past(command_pending) ? state == SEQ_PARK : state == SEQ_CLEAR) && !dma_active;
  endproperty
  a_end: assert property (p_end) else $error("transaction end wrong");

  property p_stall;
    @(posedge ref_clk) disable iff (!rst_n)
      dma_req && state != SEQ_XFER |-> !local_ready_in;
  endproperty
  a_stall: assert property (p_stall) else $error("local processor not stalled");

  property p_ready_pass;
    @(posedge ref_clk) disable iff (!rst_n)
      state == SEQ_XFER && dma_req && !local_read |-> local_ready_in == ready_s;
  endproperty
  a_ready_pass: assert property (p_ready_pass) else $error("host ready not passed");

  property p_defer;
    @(posedge ref_clk) disable iff (!rst_n)
      clk_en && state == SEQ_LOAD && !hold_line_s |=> state != SEQ_ACKW;
  endproperty
  a_defer: assert property (p_defer) else $error("request not deferred");

  property p_park;
    @(posedge ref_clk) disable iff (!rst_n)
      state == SEQ_PARK
      |-> host_hold_req_n_oe && host_bus_oe && !dma_active && !host_wait_status;
  endproperty
  a_park: assert property (p_park) else $error("parked hold wrong");

endmodule : command_port_dma_channel

//--- verification/host_bus_model.sv
`timescale 1ns/100ps
module host_bus_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       hold_oe,
  input  wire logic       other_hold,
  input  wire logic       wait_status,
  input  wire logic [7:0] ack_delay,
  output logic            phi2,
  output logic            hold_line_n,
  output logic            hold_ack,
  output logic            host_ready
);
  logic [7:0] ack_cnt;
  logic [2:0] rdy;
  // Free-running, offset so its edges never meet ref_clk edges
  initial
  begin
    phi2 = 1'b0;
    #33;
    forever #80 phi2 = ~phi2;
  end
  // Pulled-up shared line: any master may pull it low
  assign hold_line_n = ~(hold_oe | other_hold);
  // A slow host grants only after ack_delay cycles
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      ack_cnt <= 8'h00;
    else if (hold_line_n)
      ack_cnt <= 8'h00;
    else if (ack_cnt != 8'hFF)
      ack_cnt <= ack_cnt + 8'h01;
  assign hold_ack = !hold_line_n && ack_cnt >= ack_delay;
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      rdy <= 3'h0;
    else
      rdy <= {rdy[1:0], wait_status};
  assign host_ready = wait_status & rdy[2];
endmodule : host_bus_model

//--- verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic        ref_clk, rst_n, host_phi2, host_write_strobe, host_output_status, host_hold_ack;
  logic        host_hold_req_n_in, host_ready, priority_in_n, local_mem_read_n, page_upper;
  logic        local_mem_write_n, local_rd_ready, host_hold_req_n_oe, host_bus_oe, other_hold;
  logic        host_wait_status, host_mem_write_n, host_data_oe, priority_out_n, dma_active;
  logic        command_pending_n, local_ready_in, local_data_oe, local_rd_valid, hold_drive;
  logic [7:0]  port_addr, host_addr, host_data_in, local_data_in, host_data_out, local_data_out;
  logic [7:0]  ack_delay, d, pa;
  logic [15:0] local_addr, host_addr_out;
  int          fails, samples_checked;

  command_port_dma_channel dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'b1),
    .host_phi2(host_phi2), .port_addr(port_addr), .host_addr(host_addr),
    .host_data_in(host_data_in), .host_write_strobe(host_write_strobe),
    .host_output_status(host_output_status), .host_hold_req_n_in(host_hold_req_n_in),
    .host_hold_ack(host_hold_ack), .host_ready(host_ready), .priority_in_n(priority_in_n),
    .local_addr(local_addr), .local_mem_read_n(local_mem_read_n),
    .local_mem_write_n(local_mem_write_n), .local_data_in(local_data_in),
    .page_upper(page_upper), .local_rd_ready(local_rd_ready), .host_hold_req_n_out(hold_drive),
    .host_hold_req_n_oe(host_hold_req_n_oe), .host_bus_oe(host_bus_oe),
    .host_addr_out(host_addr_out), .host_wait_status(host_wait_status),
    .host_mem_write_n(host_mem_write_n), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .priority_out_n(priority_out_n),
    .command_pending_n(command_pending_n), .dma_active(dma_active),
    .local_ready_in(local_ready_in), .local_data_out(local_data_out),
    .local_data_oe(local_data_oe), .local_rd_valid(local_rd_valid));

  host_bus_model host (.ref_clk(ref_clk), .rst_n(rst_n), .hold_oe(host_hold_req_n_oe),
    .other_hold(other_hold), .wait_status(host_wait_status), .ack_delay(ack_delay),
    .phi2(host_phi2), .hold_line_n(host_hold_req_n_in), .hold_ack(host_hold_ack),
    .host_ready(host_ready));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input string w, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", w, e, s);
    end
  endtask : check

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  task automatic wait_sig(ref logic s, input logic v);
    int n = 0;
    while (s !== v && n < 500)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (s !== v)
    begin
      check("wait", 16'(s), 16'(v));
      results();
    end
  endtask : wait_sig

  task automatic host_out(input logic [7:0] a, input logic [7:0] v, input logic st);
    @(posedge ref_clk);
    host_addr <= a;
    host_data_in <= v;
    host_write_strobe <= 1'b1;
    host_output_status <= st;
    repeat (6) @(posedge ref_clk);
    host_write_strobe <= 1'b0;
    host_output_status <= 1'b0;
    repeat (6) @(negedge ref_clk);
  endtask : host_out

  task automatic local_rd(input logic [15:0] a);
    @(posedge ref_clk);
    local_addr <= a;
    local_mem_read_n <= 1'b0;
    @(negedge ref_clk);
    check("rd oe", 16'(local_data_oe), 16'h0001);
    @(negedge ref_clk);
    d = local_data_out;
    @(posedge ref_clk);
    local_mem_read_n <= 1'b1;
    @(negedge ref_clk);
  endtask : local_rd

  task automatic dma_go(input logic [15:0] a, input logic wr, input logic [7:0] v);
    @(posedge ref_clk);
    local_addr <= a;
    local_data_in <= v;
    local_mem_read_n <= wr;
    local_mem_write_n <= ~wr;
    @(negedge ref_clk);
    check("stall", 16'(local_ready_in), 16'h0000);
  endtask : dma_go

  task automatic dma_end(input logic wr, input logic [7:0] v);
    wait_sig(host_wait_status, 1'b1);
    check("haddr", host_addr_out, {page_upper, local_addr[14:0]});
    check("hwr", 16'(host_mem_write_n), 16'(!wr));
    check("oe", 16'({host_bus_oe, dma_active, host_data_oe}), 16'({2'b11, wr}));
    check("prio", 16'(priority_out_n), 16'h0000);
    check("hold drv", 16'({host_hold_req_n_oe, hold_drive}), 16'h0002);
    check("loe", 16'(local_data_oe), 16'(!wr));
    if (wr)
      check("hdata", 16'(host_data_out), 16'(v));
    wait_sig(local_ready_in, 1'b1);
    check("hready", 16'(host_ready), 16'h0001);
    @(negedge ref_clk);
    d = local_data_out;
    check("valid", 16'(local_rd_valid), 16'(!wr));
    @(posedge ref_clk);
    local_rd_ready <= 1'b1;
    local_mem_read_n <= 1'b1;
    local_mem_write_n <= 1'b1;
    @(posedge ref_clk);
    local_rd_ready <= 1'b0;
  endtask : dma_end

  initial
  begin
    {rst_n, host_write_strobe, host_output_status, page_upper, local_rd_ready, other_hold} = '0;
    {priority_in_n, local_mem_read_n, local_mem_write_n} = 3'b111;
    {port_addr, host_addr, host_data_in, local_data_in, local_addr} = '0;
    ack_delay = 8'h02;
    fails = 0;
    samples_checked = 0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(negedge ref_clk);
    check("idle", 16'({command_pending_n, host_hold_req_n_oe}), 16'h0002);
    check("ready", 16'({priority_out_n, local_ready_in}), 16'h0003);
    $display("test reset done");
    for (int i = 0; i < 2; i++)
    begin
      pa = i[0] ? 8'hFF : 8'h00;
      @(posedge ref_clk);
      port_addr <= pa;
      host_out(pa ^ 8'h01, 8'hA5, 1'b1);
      check("pend", 16'(command_pending_n), 16'h0001);
      host_out(pa, 8'hA5, 1'b0);
      check("pend", 16'(command_pending_n), 16'h0001);
      host_out(pa, pa ^ 8'h5A, 1'b1);
      check("pend", 16'(command_pending_n), 16'h0000);
      wait_sig(host_hold_req_n_oe, 1'b1);
      local_rd(16'h1800);
      check("status", 16'(d[0]), 16'h0001);
      local_rd(16'h1400);
      check("byte", 16'(d), 16'(pa ^ 8'h5A));
      check("pend", 16'(command_pending_n), 16'h0001);
      local_rd(16'h1800);
      check("status", 16'(d[0]), 16'h0000);
      wait_sig(host_hold_req_n_oe, 1'b0);
    end
    $display("test command port done");
    for (int i = 0; i < 2; i++)
    begin
      @(posedge ref_clk);
      page_upper <= i[0];
      host_data_in <= 8'hC3 ^ i[7:0];
      dma_go(16'h8000, 1'b1, 8'h3C);
      dma_end(1'b1, 8'h3C);
      wait_sig(host_hold_req_n_oe, 1'b0);
      dma_go(16'hFFFF, 1'b0, 8'h00);
      dma_end(1'b0, 8'h00);
      check("dma rd", 16'(d), 16'(8'hC3 ^ i[7:0]));
    end
    $display("test dma done");
    host_out(8'hFF, 8'h77, 1'b1);
    dma_go(16'h9234, 1'b1, 8'h11);
    dma_end(1'b1, 8'h11);
    repeat (20) @(negedge ref_clk);
    check("park", 16'({host_hold_req_n_oe, dma_active}), 16'h0002);
    dma_go(16'hA000, 1'b0, 8'h00);
    dma_end(1'b0, 8'h00);
    local_rd(16'h1400);
    check("byte", 16'(d), 16'h0077);
    wait_sig(host_hold_req_n_oe, 1'b0);
    $display("test parked done");
    @(posedge ref_clk);
    priority_in_n <= 1'b0;
    dma_go(16'h8001, 1'b1, 8'h22);
    repeat (40) @(negedge ref_clk);
    check("prio", 16'(priority_out_n), 16'h0000);
    check("hold", 16'(host_hold_req_n_oe), 16'h0000);
    @(posedge ref_clk);
    priority_in_n <= 1'b1;
    // Another master takes the bus while this one has a transfer request pending
    other_hold <= 1'b1;
    repeat (40) @(negedge ref_clk);
    check("hold", 16'(host_hold_req_n_oe), 16'h0000);
    @(posedge ref_clk);
    other_hold <= 1'b0;
    dma_end(1'b1, 8'h22);
    @(posedge ref_clk);
    ack_delay <= 8'd80;
    dma_go(16'h8002, 1'b1, 8'h33);
    wait_sig(host_hold_req_n_oe, 1'b1);
    check("prio", 16'(priority_out_n), 16'h0000);
    @(posedge ref_clk);
    priority_in_n <= 1'b0;
    repeat (24) @(negedge ref_clk);
    check("abort", 16'(host_hold_req_n_oe), 16'h0000);
    @(posedge ref_clk);
    priority_in_n <= 1'b1;
    ack_delay <= 8'h02;
    dma_end(1'b1, 8'h33);
    $display("test priority done");
    results();
  end
endmodule : tb_top
